// ---- rtl/smf_pkg.sv ----
// shared constants, register map and carrier types of the port multicast filter
package smf_pkg;

  localparam int          ADDR_W         = 64;
  localparam int          CFG_ADDR_W     = 12;
  localparam int          NUM_REGS       = 11;

  // register byte offsets in the capability window
  localparam logic [11:0] OFS_CONTROL    = 12'he04;
  localparam logic [11:0] OFS_WIN_LO     = 12'he08;
  localparam logic [11:0] OFS_WIN_HI     = 12'he0c;
  localparam logic [11:0] OFS_ACCEPT_LO  = 12'he10;
  localparam logic [11:0] OFS_ACCEPT_HI  = 12'he14;
  localparam logic [11:0] OFS_DENY_LO    = 12'he18;
  localparam logic [11:0] OFS_DENY_HI    = 12'he1c;
  localparam logic [11:0] OFS_UNTR_LO    = 12'he20;
  localparam logic [11:0] OFS_UNTR_HI    = 12'he24;
  localparam logic [11:0] OFS_OVL_LO     = 12'he28;
  localparam logic [11:0] OFS_OVL_HI     = 12'he2c;

  // register indices, counted from the control word
  localparam int          IDX_CONTROL    = 0;
  localparam int          IDX_WIN_LO     = 1;
  localparam int          IDX_WIN_HI     = 2;
  localparam int          IDX_ACCEPT_LO  = 3;
  localparam int          IDX_ACCEPT_HI  = 4;
  localparam int          IDX_DENY_LO    = 5;
  localparam int          IDX_DENY_HI    = 6;
  localparam int          IDX_UNTR_LO    = 7;
  localparam int          IDX_UNTR_HI    = 8;
  localparam int          IDX_OVL_LO     = 9;
  localparam int          IDX_OVL_HI     = 10;

  // field positions
  localparam int          POS_ENABLE     = 31;
  localparam int          POS_IN_USE     = 16;
  localparam int          POS_BASE_LO    = 12;
  localparam int          POS_OVL_BASE   = 6;
  localparam int          FIELD6_W       = 6;

  // writable bits per register; everything else reads as stored zero or a constant
  localparam logic [31:0] WMASK_CONTROL  = 32'h803f_0000;
  localparam logic [31:0] WMASK_WIN_LO   = 32'hffff_f03f;
  localparam logic [31:0] WMASK_FULL     = 32'hffff_ffff;
  // read-only capability bits: ecrc generation supported, 64 groups supported
  localparam logic [31:0] RO_CONTROL     = 32'h0000_803f;
  localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;
  localparam logic [5:0]  GROUPS_SUPPORTED = 6'h3f;
  localparam logic [5:0]  OVL_MIN_LOG2   = 6'h06;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              untranslated;
    logic              mem_request;
  } smf_tlp_t;

  typedef struct packed {
    smf_tlp_t          tlp;
    logic              mc_hit;
    logic              mc_deliver;
    logic [5:0]        group;
  } smf_result_t;

  typedef struct packed {
    logic              we;
    logic [CFG_ADDR_W-1:0] addr;
    logic [3:0]        be;
    logic [31:0]       wdata;
  } smf_cfg_req_t;

endpackage : smf_pkg

// ---- rtl/smf_filter.sv ----
// per-port multicast window, group filter and address overlay
`timescale 1ns/100ps

// What this block does
// - multicast handling happens only while the global enable bit is set
// - low six bits of window base low give the group number bit position
// - window base low holds address bits 31:12; bits 11:6 are reserved
// - window base high holds address bits 63:32, forming a 64-bit base
// - groups set in the accept vector are delivered out of this port unless a deny vector blocks them
// - groups set in the deny vector are never sent by this port
// - untranslated TLPs of groups set in the untranslated deny vector are blocked
// - vector bits above the groups-in-use count are ignored
// - overlay is off while the overlay size is below six
// - overlay size of six or more is log2 of the window in bytes
// - multicast TLPs leaving this port get their address replaced into the overlay
// - at an upstream port the overlay maps multicast space onto host memory
// - groups in use field holds count minus one, ignored when disabled
// - read-only field reports sixty-four groups supported as count minus one
module smf_filter
  import smf_pkg::*;
(
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  // configuration access
  input  wire logic                 cfg_req,
  input  wire smf_pkg::smf_cfg_req_t cfg_cmd,
  output      logic                 cfg_ready,
  output      logic                 cfg_ack,
  output      logic [31:0]          cfg_rdata,
  // serial eeprom / i2c preload
  input  wire logic                 load_we,
  input  wire logic [smf_pkg::CFG_ADDR_W-1:0] load_addr,
  input  wire logic [31:0]          load_wdata,
  // tlp from the fabric
  input  wire logic                 in_valid,
  input  wire smf_pkg::smf_tlp_t    in_tlp,
  output      logic                 in_ready,
  // tlp toward the egress link
  output      logic                 out_valid,
  output      smf_pkg::smf_result_t out_result,
  input  wire logic                 out_ready
);
  import smf_pkg::*;

  logic [31:0]       regs_reg [NUM_REGS];
  logic [31:0]       regs_next [NUM_REGS];
  logic              ack_reg;
  logic              ack_next;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              ovalid_reg;
  logic              ovalid_next;
  smf_result_t       result_reg;
  smf_result_t       result_next;

  // byte offset to register index; returns NUM_REGS for an unmapped address
  function automatic int reg_index(input logic [CFG_ADDR_W-1:0] a);
    int idx;
    idx = NUM_REGS;
    if (a[1:0] == 2'b00 && a >= OFS_CONTROL && a <= OFS_OVL_HI) begin
      idx = int'((a - OFS_CONTROL) >> 2);
    end
    return idx;
  endfunction : reg_index

  function automatic logic [31:0] write_mask(input int idx);
    logic [31:0] m;
    m = WMASK_FULL;
    if (idx == IDX_CONTROL) begin
      m = WMASK_CONTROL;
    end else if (idx == IDX_WIN_LO) begin
      m = WMASK_WIN_LO;
    end
    return m;
  endfunction : write_mask

  function automatic logic [31:0] byte_mask(input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return m;
  endfunction : byte_mask

  // ones in bit positions 0..n, the groups in use
  function automatic logic [63:0] low_ones(input logic [5:0] n);
    logic [63:0] m;
    m = 64'hffff_ffff_ffff_ffff >> (7'd63 - {1'b0, n});
    return m;
  endfunction : low_ones

  // configuration fields seen by the filter
  logic              fanout_on;
  logic [5:0]        group_bit_lsb;
  logic [5:0]        groups_in_use;
  logic [63:0]       window_base;
  logic [63:0]       group_accept_vector;
  logic [63:0]       group_deny_vector;
  logic [63:0]       group_deny_untranslated_vector;
  logic [5:0]        overlay_window_log2;
  logic [63:0]       overlay_base;

  assign fanout_on     = regs_reg[IDX_CONTROL][POS_ENABLE];
  assign groups_in_use = regs_reg[IDX_CONTROL][POS_IN_USE +: FIELD6_W];
  assign group_bit_lsb = regs_reg[IDX_WIN_LO][FIELD6_W-1:0];
  assign window_base   = {regs_reg[IDX_WIN_HI],
                          regs_reg[IDX_WIN_LO][31:POS_BASE_LO], 12'h000};
  assign group_accept_vector            = {regs_reg[IDX_ACCEPT_HI], regs_reg[IDX_ACCEPT_LO]};
  assign group_deny_vector              = {regs_reg[IDX_DENY_HI], regs_reg[IDX_DENY_LO]};
  assign group_deny_untranslated_vector = {regs_reg[IDX_UNTR_HI], regs_reg[IDX_UNTR_LO]};
  assign overlay_window_log2 = regs_reg[IDX_OVL_LO][FIELD6_W-1:0];
  assign overlay_base  = {regs_reg[IDX_OVL_HI], regs_reg[IDX_OVL_LO][31:POS_OVL_BASE], 6'h00};

  // preload has the port; software waits out the cycle rather than losing a write
  assign cfg_ready = !load_we;

  // register file
  always_comb begin
    int cidx;
    int lidx;
    cidx = reg_index(cfg_cmd.addr);
    lidx = reg_index(load_addr);
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    ack_next   = 1'b0;
    rdata_next = rdata_reg;
    if (load_we) begin
      if (lidx < NUM_REGS) begin
        regs_next[lidx] = load_wdata & write_mask(lidx);
      end
    end else if (cfg_req) begin
      ack_next = 1'b1;
      if (cfg_cmd.we) begin
        if (cidx < NUM_REGS) begin
          regs_next[cidx] = (regs_reg[cidx] & ~(write_mask(cidx) & byte_mask(cfg_cmd.be)))
                          | (cfg_cmd.wdata & write_mask(cidx) & byte_mask(cfg_cmd.be));
        end
      end else if (cidx < NUM_REGS) begin
        rdata_next = regs_reg[cidx];
        if (cidx == IDX_CONTROL) begin
          rdata_next = regs_reg[cidx] | RO_CONTROL;
        end
      end else begin
        rdata_next = RESET_VALUE;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= RESET_VALUE;
      end
      ack_reg   <= 1'b0;
      rdata_reg <= RESET_VALUE;
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign cfg_ack   = ack_reg;
  assign cfg_rdata = rdata_reg;

  // filter datapath: one register stage, stalls when the egress side holds off
  logic [63:0]       offset;
  logic [63:0]       scaled;
  logic              in_window;
  logic [5:0]        group;
  logic [63:0]       valid_groups;
  logic              deliver;
  logic              overlay_on;
  logic [63:0]       keep_mask;
  logic [63:0]       new_addr;

  assign in_ready = !ovalid_reg || out_ready;

  always_comb begin
    // base low bits below the position are zero by software contract, so plain subtraction suffices
    offset       = in_tlp.addr - window_base;
    scaled       = offset >> group_bit_lsb;
    // the position below twelve is undefined; nothing here guards against it
    in_window    = fanout_on && in_tlp.mem_request && (in_tlp.addr >= window_base)
                && (scaled[63:6] == 58'h0) && (scaled[5:0] <= groups_in_use);
    group        = scaled[5:0];
    valid_groups = low_ones(groups_in_use);
    deliver      = in_window
                && (group_accept_vector[group] && valid_groups[group])
                && !(group_deny_vector[group] && valid_groups[group])
                && !(in_tlp.untranslated && group_deny_untranslated_vector[group]
                     && valid_groups[group]);
    overlay_on   = (overlay_window_log2 >= OVL_MIN_LOG2);
    keep_mask    = low_ones(overlay_window_log2 - 6'h01);
    // same replacement at an upstream port, where the base points into host memory
    new_addr     = (overlay_base & ~keep_mask) | (in_tlp.addr & keep_mask);
    ovalid_next  = ovalid_reg;
    result_next  = result_reg;
    if (in_ready) begin
      ovalid_next = in_valid;
      if (in_valid) begin
        result_next.tlp        = in_tlp;
        result_next.mc_hit     = in_window;
        result_next.mc_deliver = deliver;
        result_next.group      = in_window ? group : 6'h00;
        if (deliver && overlay_on) begin
          result_next.tlp.addr = new_addr;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ovalid_reg <= 1'b0;
      result_reg <= '0;
    end else begin
      ovalid_reg <= ovalid_next;
      result_reg <= result_next;
    end
  end

  assign out_valid  = ovalid_reg;
  assign out_result = result_reg;

endmodule : smf_filter

// ---- test/smf_filter_props.sv ----
// assertion checker for the port multicast filter
`timescale 1ns/100ps
module smf_filter_props
  import smf_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 arst_n,
  input wire logic                 cfg_req,
  input wire smf_pkg::smf_cfg_req_t cfg_cmd,
  input wire logic                 cfg_ready,
  input wire logic                 cfg_ack,
  input wire logic [31:0]          cfg_rdata,
  input wire logic                 load_we,
  input wire logic                 in_valid,
  input wire logic                 in_ready,
  input wire logic                 out_valid,
  input wire smf_pkg::smf_result_t out_result,
  input wire logic                 out_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_taken;
    cfg_req && cfg_ready;
  endsequence
  sequence s_rd_ctrl;
    s_taken ##0 (!cfg_cmd.we && cfg_cmd.addr == OFS_CONTROL);
  endsequence
  // back-to-back requests keep ack high, so the pulse shape is only checked for a lone request
  property p_ack; s_taken ##1 !(cfg_req && cfg_ready) |-> cfg_ack ##1 !cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("config ack not a single pulse");
  property p_no_ack; !(cfg_req && cfg_ready) |=> !cfg_ack; endproperty
  a_no_ack: assert property (p_no_ack) else $error("config ack without request");
  property p_preload; cfg_ready == !load_we; endproperty
  a_preload: assert property (p_preload) else $error("preload does not stall software");
  property p_ctrl_ro; s_rd_ctrl |=> cfg_rdata[5:0] == GROUPS_SUPPORTED && cfg_rdata[15]; endproperty
  a_ctrl_ro: assert property (p_ctrl_ro) else $error("capability bits wrong");
  property p_in_ready; in_ready == (!out_valid || out_ready); endproperty
  a_in_ready: assert property (p_in_ready) else $error("in_ready wrong");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_result); endproperty
  a_hold: assert property (p_hold) else $error("result dropped while stalled");
  property p_take; in_valid && in_ready |=> out_valid; endproperty
  a_take: assert property (p_take) else $error("accepted tlp not presented");
  property p_unicast; out_valid && !out_result.mc_hit |-> !out_result.mc_deliver && out_result.group == 6'h00;
  endproperty
  a_unicast: assert property (p_unicast) else $error("unicast marked as delivered");
endmodule : smf_filter_props

bind smf_filter smf_filter_props u_props (.clock(clock), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_cmd(cfg_cmd),
  .cfg_ready(cfg_ready), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .load_we(load_we), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .out_result(out_result), .out_ready(out_ready));

// ---- test/smf_egress_model.sv ----
// egress link model that stalls the filter output in a fixed pattern
`timescale 1ns/100ps
module smf_egress_model (
  input  wire logic clock,
  input  wire logic arst_n,
  output      logic out_ready
);
  logic [1:0] cnt_reg;
  // ready three cycles of four, so results must hold across a stall
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'h1;
  end
  assign out_ready = (cnt_reg != 2'h1);
endmodule : smf_egress_model

// ---- test/smf_filter_bench.sv ----
// self-checking bench for the port multicast filter
`timescale 1ns/100ps
module smf_filter_bench;
  import smf_pkg::*;
  logic clock, arst_n, cfg_req, cfg_ready, cfg_ack, load_we, in_valid, in_ready, out_valid, out_ready;
  smf_cfg_req_t cfg_cmd;
  logic [31:0]  cfg_rdata, load_wdata, d;
  logic [3:0]   be_sel;
  logic [11:0]  load_addr;
  smf_tlp_t     in_tlp;
  smf_result_t  out_result;
  int           n_fail, cmp_count;
  smf_filter dut (.clock(clock), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_cmd(cfg_cmd), .cfg_ready(cfg_ready),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .load_we(load_we), .load_addr(load_addr), .load_wdata(load_wdata),
    .in_valid(in_valid), .in_tlp(in_tlp), .in_ready(in_ready), .out_valid(out_valid), .out_result(out_result),
    .out_ready(out_ready));
  smf_egress_model u_egress (.clock(clock), .arst_n(arst_n), .out_ready(out_ready));
  task end_of_test;
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task cfg(input logic we, input logic [11:0] a, input logic [31:0] w);
    @(posedge clock); #1;
    cfg_req = 1'b1;
    cfg_cmd = '{we: we, addr: a, be: be_sel, wdata: w};
    @(posedge clock); #1;
    cfg_req = 1'b0;
    chk("cfg_ack", 80'(cfg_ack), 80'(1'b1));
    d = cfg_rdata;
  endtask : cfg
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 32'h0);
    chk("cfg_rdata", 80'(d), 80'(exp));
  endtask : rd_chk
  // one tlp in, its result compared in the cycle the egress takes it
  task tx(input logic [63:0] a, input logic u, input logic h, input logic dl, input logic [5:0] g,
          input logic [63:0] ea);
    logic ok;
    @(posedge clock); #1;
    in_valid = 1'b1;
    in_tlp = '{addr: a, untranslated: u, mem_request: 1'b1};
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      #18 ok = in_ready;
      @(posedge clock); #1;
    end
    in_valid = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      #18 ok = out_valid && out_ready;
      if (ok) chk("out_result", 80'(out_result), 80'({ea, u, 1'b1, h, dl, g}));
      @(posedge clock); #1;
    end
    if (!ok) begin
      n_fail++;
      end_of_test();
    end
  endtask : tx
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    {arst_n, cfg_req, load_we, in_valid, load_addr, load_wdata} = '0;
    cfg_cmd = '0;
    be_sel = 4'hf;
    in_tlp = '0;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock);
    #1 arst_n = 1'b1;
    // reset values of the whole map, plus one unmapped word
    for (int i = 0; i < NUM_REGS; i++) rd_chk(OFS_CONTROL + 12'(4 * i), i == 0 ? RO_CONTROL : RESET_VALUE);
    rd_chk(12'he30, 32'h0);
    cfg(1'b1, OFS_WIN_LO, 32'hffff_ffff);
    rd_chk(OFS_WIN_LO, WMASK_WIN_LO);
    // position and base made legal before the enable goes on
    cfg(1'b1, OFS_WIN_LO, 32'h0000_000c);
    cfg(1'b1, OFS_CONTROL, 32'hffff_ffff);
    rd_chk(OFS_CONTROL, WMASK_CONTROL | RO_CONTROL);
    @(posedge clock); #1;
    load_we = 1'b1;
    load_addr = OFS_ACCEPT_LO;
    load_wdata = 32'h1234_5678;
    #1 chk("cfg_ready", 80'(cfg_ready), 80'(1'b0));
    @(posedge clock); #1;
    load_we = 1'b0;
    rd_chk(OFS_ACCEPT_LO, 32'h1234_5678);
    // only byte lane 1 of this write may land
    be_sel = 4'h2;
    cfg(1'b1, OFS_ACCEPT_HI, 32'hffff_ffff);
    be_sel = 4'hf;
    rd_chk(OFS_ACCEPT_HI, 32'h0000_ff00);
    // four groups at bit 12 above a base of 1_0000_0000
    cfg(1'b1, OFS_CONTROL, 32'h8003_0000);
    cfg(1'b1, OFS_WIN_LO, 32'h0000_000c);
    cfg(1'b1, OFS_WIN_HI, 32'h0000_0001);
    cfg(1'b1, OFS_ACCEPT_LO, 32'h0000_001f);
    cfg(1'b1, OFS_DENY_LO, 32'h0000_0002);
    cfg(1'b1, OFS_UNTR_LO, 32'h0000_0004);
    tx(64'h1_0000_0040, 1'b0, 1'b1, 1'b1, 6'h0, 64'h1_0000_0040);
    tx(64'h1_0000_1000, 1'b0, 1'b1, 1'b0, 6'h1, 64'h1_0000_1000);
    tx(64'h1_0000_2000, 1'b1, 1'b1, 1'b0, 6'h2, 64'h1_0000_2000);
    tx(64'h1_0000_2008, 1'b0, 1'b1, 1'b1, 6'h2, 64'h1_0000_2008);
    tx(64'h1_0000_4000, 1'b0, 1'b0, 1'b0, 6'h0, 64'h1_0000_4000);
    tx(64'h0_ffff_f000, 1'b0, 1'b0, 1'b0, 6'h0, 64'h0_ffff_f000);
    cfg(1'b1, OFS_OVL_LO, 32'h0000_0145);
    tx(64'h1_0000_3123, 1'b0, 1'b1, 1'b1, 6'h3, 64'h1_0000_3123);
    cfg(1'b1, OFS_OVL_LO, 32'habcd_e00c);
    cfg(1'b1, OFS_OVL_HI, 32'h0000_0002);
    tx(64'h1_0000_3123, 1'b0, 1'b1, 1'b1, 6'h3, 64'h2_abcd_e123);
    tx(64'h1_0000_1004, 1'b0, 1'b1, 1'b0, 6'h1, 64'h1_0000_1004);
    cfg(1'b1, OFS_CONTROL, 32'h0003_0000);
    tx(64'h1_0000_0040, 1'b0, 1'b0, 1'b0, 6'h0, 64'h1_0000_0040);
    // a reset in mid-run drops what software wrote
    @(posedge clock); #1 arst_n = 1'b0;
    @(posedge clock); #1 arst_n = 1'b1;
    rd_chk(OFS_ACCEPT_LO, RESET_VALUE);
    end_of_test();
  end
endmodule : smf_filter_bench
